// ---- verilog/led_gs_defines.svh ----
/*
  Command identifiers, register defaults, write masks and field positions
  of the grayscale buffer and PWM core.
  Assumes inclusion by bare name from the design modules and the test bench.
*/
`ifndef LED_GS_DEFINES_SVH
`define LED_GS_DEFINES_SVH
`define ID_CFG0_WR 16'hAA00
`define ID_CFG1_WR 16'hAA01
`define ID_ODL_WR 16'hAA0E
`define ID_SDL_WR 16'hAA0F
`define ID_CFG0_RD 16'hAA60
`define ID_CFG1_RD 16'hAA61
`define ID_ODL_RD 16'hAA6E
`define ID_SDL_RD 16'hAA6F
`define ID_OPEN_HI 16'hAAA0
`define ID_OPEN_LO 16'hAAA1
`define ID_SHORT_HI 16'hAAA2
`define ID_SHORT_LO 16'hAAA3
`define ID_OPEN_CH 16'hAAA4
`define ID_SHORT_CH 16'hAAA5
`define ID_PWR_SAVE 16'hAA90
`define ID_STBY_CLR 16'hAAB0
`define ID_STBY_EN 16'hAAB1
`define ID_DEFAULTS 16'hAA80
`define ID_GS_STORE 16'hAA30
`define ID_FRAME_SYNC 16'hAAF0
`define CFG0_RESET 48'h2000_E000_0107
`define CFG0_WMASK 48'h9FF1_F1FF_F11F
`define CFG1_RESET 48'h00E0_0094_A400
`define CFG1_WMASK 48'h7FFF_FFFF_FFFF
`define SEL_RESET 48'h0000_0000_0000
`define SCAN_LSB 16
`define SUBP_LSB 22
`define SEGLEN_LSB 0
`define LSWT_LSB 37
`define STEP_R_LSB 10
`define STEP_G_LSB 15
`define STEP_B_LSB 20
`define SEG_LONG_CODE 10'h3FF
`define SEG_LONG_LAST 11'h3FF
`define SEG_SHORT_LAST 11'h07F
`define UNIT_LAST 4'hF
`define HEAD_LAST_BIT 7'h10
`define END_ONES 5'h11
`define MIN_FRAME_BITS 7'h22
`define GROUP_BITS 7'h11
`define TX_BITS 6'h34
`endif

// ---- verilog/led_gs_pkg.sv ----
/*
  State types of the link front end and the buffer and PWM core.
  Includes no header and uses none of the defines.
*/
package led_gs_pkg;
  typedef enum logic [1:0] {PH_SHOW = 2'b01, PH_SWITCH = 2'b10} phase_type;

  typedef struct packed {
    logic rs1, rs2;
    logic busy, hok, tgl;
    logic [6:0] nbits;
    logic [4:0] ones;
    logic [67:0] sh;
    logic [15:0] head;
    logic [47:0] data;
    logic r1, r2, r3, seen;
    logic [51:0] tx;
    logic [5:0] txn;
    logic sout;
  } link_state_type;

  typedef struct packed {
    logic c1, c2, c3, cseen;
    logic [47:0] cfg0, cfg1, odl, sdl;
    logic bank_sel, frame_done;
    logic [5:0] wr_line;
    logic [3:0] wr_unit;
    logic standby, matrix_power_save_cmd_arm, all_zero, power_save;
    logic [47:0] rd_word;
    logic rsp_tgl, we;
    logic [10:0] waddr;
    logic [47:0] wdata;
    phase_type phase;
    logic [6:0] sub;
    logic [5:0] dline;
    logic [10:0] seg_cnt;
    logic [3:0] sw_cnt;
    logic [2:0][4:0] r;
    logic [2:0][22:0] pos;
    logic [2:0][12:0] base;
    logic [15:0][47:0] gs, nx;
    logic [47:0] ch_on;
  } core_state_type;
endpackage

// ---- verilog/gs_frame_ram.sv ----
/*
  Simple dual-port grayscale memory, one write and one read port.
  Assumes a single clock; read data appear one edge after the address.
*/
`timescale 1ns/1ns
module gs_frame_ram #(
  parameter int WIDTH = 48,
  parameter int ADDR_W = 11
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [ADDR_W-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ---- verilog/serial_link_port.sv ----
/*
  Serial link front end on the link clock: frame receiver, read answer
  transmitter, toggle handshakes toward the core clock.
  Assumes sin is stable at sclk rising edges and sclk runs continuously.
*/
`timescale 1ns/1ns
`include "led_gs_defines.svh"
module serial_link_port (
  input wire logic sclk,
  input wire logic rst,
  input wire logic sin,
  output logic sout,
  output logic cmd_tgl,
  output logic [15:0] cmd_head,
  output logic [47:0] cmd_data,
  input wire logic rsp_tgl,
  input wire logic [47:0] rsp_data
);
  led_gs_pkg::link_state_type q, d;
  logic early;

  // A high last check bit joins the end marker, so the end is seen one
  // bit early and the word sits one place lower in the shifter. Frames
  // longer than the saturating bit count are not realigned.
  assign early = (q.nbits % `GROUP_BITS) == `HEAD_LAST_BIT;

  always_comb begin
    d = q;
    d.rs1 = rst;
    d.rs2 = q.rs1;
    d.r1 = rsp_tgl;
    d.r2 = q.r1;
    d.r3 = q.r2;
    if (!q.busy) begin
      if (!sin) begin
        d.busy = 1'b1;
        d.nbits = 7'h00;
        d.ones = 5'h00;
      end
    end else begin
      d.sh = {q.sh[66:0], sin};
      if (q.nbits != 7'h7F) begin
        d.nbits = q.nbits + 7'h01;
      end
      d.ones = sin ? q.ones + 5'h01 : 5'h00;
      if (q.nbits == `HEAD_LAST_BIT) begin
        d.head = q.sh[15:0];
        d.hok = (sin == !q.sh[0]);
      end
      if (sin && q.ones == `END_ONES) begin
        d.busy = 1'b0;
        // Last three 17-bit groups before the end marker carry the word
        if (q.nbits + {6'h00, early} >= `MIN_FRAME_BITS && q.hok) begin
          d.tgl = !q.tgl;
          d.data = early ? {q.sh[66:51], q.sh[49:34], q.sh[32:17]} :
                           {q.sh[67:52], q.sh[50:35], q.sh[33:18]};
        end
      end
    end
    // Answer word is held still by the core until its next read
    if (q.r2 == q.r3 && q.r3 != q.seen) begin
      d.seen = q.r3;
      d.tx = {1'b0, rsp_data[47:32], !rsp_data[32], rsp_data[31:16],
              !rsp_data[16], rsp_data[15:0], !rsp_data[0]};
      d.txn = `TX_BITS;
    end else if (q.txn != 6'h00) begin
      d.tx = {q.tx[50:0], 1'b1};
      d.txn = q.txn - 6'h01;
    end
    d.sout = (q.txn != 6'h00) ? q.tx[51] : sin;
    if (q.rs2) begin
      d = '0;
      d.rs1 = rst;
      d.rs2 = q.rs1;
      d.sout = 1'b1;
    end
  end

  always_ff @(posedge sclk) begin
    q <= d;
  end

  assign sout = q.sout;
  assign cmd_tgl = q.tgl;
  assign cmd_head = q.head;
  assign cmd_data = q.data;
endmodule

// ---- verilog/led_gs_core.sv ----
/*
  Double-buffered grayscale memory with write pointers, command decode
  for the serial link and spread-segment PWM timing of the scan matrix.
  Assumes detection warnings arrive synchronous to clk and that the
  grayscale clock equals clk; sclk is the link clock, unrelated in phase.
*/
`timescale 1ns/1ns
`include "led_gs_defines.svh"
module led_gs_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sin,
  output logic sout,
  input wire logic [63:0] open_line_warn,
  input wire logic [63:0] short_line_warn,
  input wire logic [47:0] open_chan_warn,
  input wire logic [47:0] short_chan_warn,
  output logic [47:0] ch_on,
  output logic [5:0] scan_line,
  output logic line_blank,
  output logic standby,
  output logic power_save
);
  led_gs_pkg::core_state_type q, d;
  logic cmd_tgl;
  logic [15:0] cmd_head;
  logic [47:0] cmd_data;
  logic [47:0] rdata;
  logic [10:0] raddr;
  logic fire, known, rd_go;
  logic [47:0] rd_val;
  logic [5:0] scan_last, next_line;
  logic [6:0] n_last;
  logic [10:0] seg_last;
  logic [3:0] sw_last;
  logic [2:0][5:0] t;
  logic [2:0][13:0] nt;
  logic [2:0][12:0] nbase;
  logic [47:0] hit;

  serial_link_port link (
    .sclk(sclk),
    .rst(rst),
    .sin(sin),
    .sout(sout),
    .cmd_tgl(cmd_tgl),
    .cmd_head(cmd_head),
    .cmd_data(cmd_data),
    .rsp_tgl(q.rsp_tgl),
    .rsp_data(q.rd_word)
  );

  // Bank bit 0 is A; the shown bank is always the one not written
  gs_frame_ram #(.WIDTH(48), .ADDR_W(11)) ram (
    .clk(clk),
    .we(q.we),
    .waddr(q.waddr),
    .wdata(q.wdata),
    .raddr(raddr),
    .rdata(rdata)
  );

  assign fire = (q.c2 == q.c3) && (q.c3 != q.cseen);
  assign scan_last = q.cfg0[`SCAN_LSB +: 6];
  assign n_last = {q.cfg0[`SUBP_LSB +: 3], 4'hF};
  assign seg_last = (q.cfg1[`SEGLEN_LSB +: 10] == `SEG_LONG_CODE) ?
                    `SEG_LONG_LAST : `SEG_SHORT_LAST;
  assign sw_last = (q.cfg1[`LSWT_LSB +: 4] == 4'h0) ? 4'h0 :
                   q.cfg1[`LSWT_LSB +: 4] - 4'h1;
  assign next_line = (q.dline == scan_last) ? 6'h00 : q.dline + 6'h01;
  assign raddr = {!q.bank_sel, next_line, q.seg_cnt[3:0]};
  assign t[0] = {1'b0, q.cfg1[`STEP_R_LSB +: 5]} + 6'h01;
  assign t[1] = {1'b0, q.cfg1[`STEP_G_LSB +: 5]} + 6'h01;
  assign t[2] = {1'b0, q.cfg1[`STEP_B_LSB +: 5]} + 6'h01;

  generate
    for (genvar c = 0; c < 3; c++) begin : g_col
      assign nt[c] = ({1'b0, n_last} + 8'h01) * t[c];
      assign nbase[c] = (q.dline != scan_last) ? q.base[c] :
                        (q.sub == n_last) ? 13'h0000 :
                        q.base[c] + {7'h00, t[c]};
    end
    // Red, green, blue of unit u drive channels 3u, 3u+1, 3u+2
    for (genvar ch = 0; ch < 48; ch++) begin : g_ch
      assign hit[ch] = q.pos[ch % 3] <
                       {7'h00, q.gs[ch / 3][16 * (ch % 3) +: 16]};
    end
  endgenerate

  always_comb begin
    d = q;
    known = 1'b0;
    rd_go = 1'b0;
    rd_val = 48'h0000_0000_0000;
    d.we = 1'b0;
    d.frame_done = 1'b0;
    d.c1 = cmd_tgl;
    d.c2 = q.c1;
    d.c3 = q.c2;
    if (fire) begin
      d.cseen = q.c3;
      known = 1'b1;
      case (cmd_head)
        `ID_CFG0_WR: d.cfg0 = (q.cfg0 & ~`CFG0_WMASK) | (cmd_data & `CFG0_WMASK);
        `ID_CFG1_WR: d.cfg1 = (q.cfg1 & ~`CFG1_WMASK) | (cmd_data & `CFG1_WMASK);
        `ID_ODL_WR: d.odl = cmd_data;
        `ID_SDL_WR: d.sdl = cmd_data;
        `ID_CFG0_RD: begin rd_go = 1'b1; rd_val = q.cfg0; end
        `ID_CFG1_RD: begin rd_go = 1'b1; rd_val = q.cfg1; end
        `ID_ODL_RD: begin rd_go = 1'b1; rd_val = q.odl; end
        `ID_SDL_RD: begin rd_go = 1'b1; rd_val = q.sdl; end
        `ID_OPEN_HI: begin
          rd_go = 1'b1;
          rd_val = {32'h0000_0000, open_line_warn[63:48]};
        end
        `ID_OPEN_LO: begin rd_go = 1'b1; rd_val = open_line_warn[47:0]; end
        `ID_SHORT_HI: begin
          rd_go = 1'b1;
          rd_val = {32'h0000_0000, short_line_warn[63:48]};
        end
        `ID_SHORT_LO: begin rd_go = 1'b1; rd_val = short_line_warn[47:0]; end
        `ID_OPEN_CH: begin rd_go = 1'b1; rd_val = open_chan_warn; end
        `ID_SHORT_CH: begin rd_go = 1'b1; rd_val = short_chan_warn; end
        `ID_PWR_SAVE: d.matrix_power_save_cmd_arm = 1'b1;
        `ID_STBY_CLR: d.standby = 1'b0;
        `ID_STBY_EN: d.standby = 1'b1;
        `ID_DEFAULTS: begin
          d.cfg0 = `CFG0_RESET;
          d.cfg1 = `CFG1_RESET;
          d.odl = `SEL_RESET;
          d.sdl = `SEL_RESET;
          d.standby = 1'b0;
          d.matrix_power_save_cmd_arm = 1'b0;
          d.power_save = 1'b0;
        end
        `ID_FRAME_SYNC: begin
          d.bank_sel = !q.bank_sel;
          d.wr_line = 6'h00;
          d.wr_unit = 4'h0;
          // Power save only if the frame just stored was all zero
          d.power_save = q.matrix_power_save_cmd_arm && q.all_zero;
          d.matrix_power_save_cmd_arm = 1'b0;
          d.all_zero = 1'b1;
        end
        `ID_GS_STORE: begin
          d.we = 1'b1;
          d.waddr = {q.bank_sel, q.wr_line, q.wr_unit};
          d.wdata = cmd_data;
          if (cmd_data != 48'h0000_0000_0000) begin
            d.all_zero = 1'b0;
            d.power_save = 1'b0;
          end
          if (q.wr_unit == `UNIT_LAST) begin
            d.wr_unit = 4'h0;
            if (q.wr_line == scan_last) begin
              d.wr_line = 6'h00;
              d.frame_done = 1'b1;
            end else begin
              d.wr_line = q.wr_line + 6'h01;
            end
          end else begin
            d.wr_unit = q.wr_unit + 4'h1;
          end
        end
        default: known = 1'b0;
      endcase
    end
    if (rd_go) begin
      d.rd_word = rd_val;
      d.rsp_tgl = !q.rsp_tgl;
    end

    case (q.phase)
      led_gs_pkg::PH_SHOW: begin
        d.seg_cnt = q.seg_cnt + 11'h001;
        // Next line is fetched early, one unit per clock
        if (q.seg_cnt != 11'h000 && q.seg_cnt <= 11'h010) begin
          d.nx[4'(q.seg_cnt[4:0] - 5'h01)] = rdata;
        end
        for (int c = 0; c < 3; c++) begin
          // Blocks of t clocks interleave over subperiods
          if ({1'b0, q.r[c]} == t[c] - 6'h01) begin
            d.r[c] = 5'h00;
            d.pos[c] = q.pos[c] + {9'h000, nt[c]} -
                       {17'h00000, t[c]} + 23'h000001;
          end else begin
            d.r[c] = q.r[c] + 5'h01;
            d.pos[c] = q.pos[c] + 23'h000001;
          end
        end
        if (q.seg_cnt == seg_last) begin
          d.phase = led_gs_pkg::PH_SWITCH;
          d.sw_cnt = 4'h0;
        end
      end
      led_gs_pkg::PH_SWITCH: begin
        if (q.sw_cnt == sw_last) begin
          d.phase = led_gs_pkg::PH_SHOW;
          d.seg_cnt = 11'h000;
          d.gs = q.nx;
          d.dline = next_line;
          if (q.dline == scan_last) begin
            d.sub = (q.sub == n_last) ? 7'h00 : q.sub + 7'h01;
          end
          d.base = nbase;
          for (int c = 0; c < 3; c++) begin
            d.r[c] = 5'h00;
            d.pos[c] = {10'h000, nbase[c]};
          end
        end else begin
          d.sw_cnt = q.sw_cnt + 4'h1;
        end
      end
      default: d.phase = led_gs_pkg::PH_SHOW;
    endcase
    d.ch_on = (q.phase == led_gs_pkg::PH_SHOW && !q.standby &&
               !q.power_save) ? hit : 48'h0000_0000_0000;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.cfg0 <= `CFG0_RESET;
      q.cfg1 <= `CFG1_RESET;
      q.all_zero <= 1'b1;
      q.phase <= led_gs_pkg::PH_SHOW;
    end else begin
      q <= d;
    end
  end

  assign ch_on = q.ch_on;
  assign scan_line = q.dline;
  assign line_blank = q.phase[1];
  assign standby = q.standby;
  assign power_save = q.power_save;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_store;
    fire && cmd_head == `ID_GS_STORE;
  endsequence
  sequence s_sync;
    fire && cmd_head == `ID_FRAME_SYNC;
  endsequence

  property p_boot;
    $fell(rst) |-> !q.bank_sel && !q.we;
  endproperty
  a_boot: assert property (p_boot)
    else $error("bank select not cleared by reset");
  property p_ptr0;
    $fell(rst) |-> q.wr_line == 6'h00 && q.wr_unit == 4'h0;
  endproperty
  a_ptr0: assert property (p_ptr0)
    else $error("write pointers not cleared by reset");
  property p_swap;
    s_sync |=> q.bank_sel != $past(q.bank_sel) && q.wr_unit == 4'h0;
  endproperty
  a_swap: assert property (p_swap)
    else $error("frame sync did not swap banks");
  property p_unit;
    s_store ##0 q.wr_unit != 4'hF |=>
      q.wr_unit == $past(q.wr_unit) + 4'h1 && $stable(q.wr_line);
  endproperty
  a_unit: assert property (p_unit)
    else $error("unit pointer did not step");
  property p_line;
    s_store ##0 (q.wr_unit == 4'hF && q.wr_line != scan_last) |=>
      q.wr_unit == 4'h0 && q.wr_line == $past(q.wr_line) + 6'h01;
  endproperty
  a_line: assert property (p_line)
    else $error("line pointer did not step");
  property p_wrap;
    s_store ##0 (q.wr_unit == 4'hF && q.wr_line == scan_last) |=>
      q.wr_line == 6'h00 && q.frame_done;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("line pointer did not wrap");
  property p_latch;
    s_store |=> q.we && q.wdata == $past(cmd_data) ##1 !q.we;
  endproperty
  a_latch: assert property (p_latch)
    else $error("store word not written");
  property p_segend;
    $rose(q.phase == led_gs_pkg::PH_SWITCH) |-> $past(q.seg_cnt) == seg_last;
  endproperty
  a_segend: assert property (p_segend)
    else $error("display interval length wrong");
  property p_defaults;
    fire && cmd_head == `ID_DEFAULTS |=>
      q.cfg0 == `CFG0_RESET && q.cfg1 == `CFG1_RESET && !q.we;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("defaults not restored");
  property p_ignore;
    fire && !known |=> $stable(q.cfg0) && $stable(q.bank_sel) &&
      $stable(q.wr_unit) && !q.we;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("unknown command changed state");
  property p_dark;
    q.standby || q.power_save |=> q.ch_on == 48'h0000_0000_0000;
  endproperty
  a_dark: assert property (p_dark)
    else $error("channels lit while dark");
  property p_selread;
    fire && cmd_head == `ID_ODL_RD |=>
      q.rd_word == $past(q.odl) && q.rsp_tgl != $past(q.rsp_tgl);
  endproperty
  a_selread: assert property (p_selread)
    else $error("line select read not answered");
  property p_swend;
    $fell(q.phase == led_gs_pkg::PH_SWITCH) |->
      $past(q.sw_cnt) == $past(sw_last);
  endproperty
  a_swend: assert property (p_swend)
    else $error("line switch interval length wrong");
endmodule

// ---- sim/serial_host_model.sv ----
/*
  Controller model on the chained serial link: sends frames, reads answers.
  Assumes sclk runs continuously from the bench; sin idles high.
*/
`timescale 1ns/1ns
module serial_host_model (
  input wire logic sclk,
  output logic sin,
  input wire logic sout
);
  initial sin = 1'b1;

  // Sixteen bits MSB first, then a check bit that keeps END unique
  task automatic put17(input logic [15:0] v);
    for (int i = 16; i >= 0; i--) begin
      @(posedge sclk);
      #5 sin = (i == 0) ? ~v[0] : v[i-1];
    end
  endtask

  task automatic send(input logic [15:0] head, input logic [47:0] word);
    @(posedge sclk);
    #5 sin = 1'b0;
    put17(head);
    put17(word[47:32]);
    put17(word[31:16]);
    put17(word[15:0]);
    @(posedge sclk);
    #5 sin = 1'b1;
    repeat (18) @(posedge sclk);
  endtask

  task automatic fetch(input logic [15:0] head, output logic [47:0] word,
                       output bit ok);
    logic [50:0] a;
    int n;
    send(head, 48'h0000_0000_0000);
    n = 0;
    while (sout !== 1'b0 && n < 64) begin
      @(negedge sclk);
      n++;
    end
    for (int i = 50; i >= 0; i--) begin
      @(negedge sclk);
      a[i] = sout;
    end
    ok = n < 64 && a[34] === ~a[35] && a[17] === ~a[18] && a[0] === ~a[1];
    word = {a[50:35], a[33:18], a[16:1]};
  endtask
endmodule

// ---- sim/led_gs_core_test.sv ----
/*
  Self-checking bench of the grayscale buffer and PWM core.
  Assumes the core's ports as declared and the partner model beside it.
*/
`timescale 1ns/1ns
`include "led_gs_defines.svh"
module led_gs_core_test;
  logic clk, rst, sclk, sin, sout, line_blank, standby, power_save;
  logic [63:0] open_line_warn, short_line_warn;
  logic [47:0] open_chan_warn, short_chan_warn, ch_on, w, v;
  logic [5:0] scan_line;
  logic [15:0] lfsr;
  logic [47:0] m1 [2];
  logic [47:0] m2 [3];
  int n_errors, n_tests, cycles;

  led_gs_core u_led_gs_core (.clk(clk), .rst(rst), .sclk(sclk), .sin(sin),
    .sout(sout), .open_line_warn(open_line_warn),
    .short_line_warn(short_line_warn), .open_chan_warn(open_chan_warn),
    .short_chan_warn(short_chan_warn), .ch_on(ch_on),
    .scan_line(scan_line), .line_blank(line_blank), .standby(standby),
    .power_save(power_save));
  serial_host_model u_serial_host_model (.sclk(sclk), .sin(sin),
    .sout(sout));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Link clock free-running at 125 ns, phase unrelated to clk
  initial begin
    sclk = 1'b0;
    #37;
    forever begin
      #62 sclk = 1'b1;
      #63 sclk = 1'b0;
    end
  end

  task automatic summarize;
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic rnd48(output logic [47:0] r);
    repeat (3) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      r = {r[31:0], lfsr};
    end
  endtask
  function automatic logic [47:0] unit_word(input logic [47:0] m, int u);
    return {{16{m[3*u+2]}}, {16{m[3*u+1]}}, {16{m[3*u]}}};
  endfunction
  function automatic logic [47:0] cfg1v(input logic [9:0] seg,
                                        input logic [3:0] sw);
    return (`CFG1_RESET & ~48'h01E0_0000_03FF) | {7'h00, sw, 27'h0, seg};
  endfunction

  task automatic check(input string what, input logic [47:0] exp,
                       input logic [47:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] id, input logic [47:0] d);
    u_serial_host_model.send(id, d);
    repeat (8) @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] id, input logic [47:0] exp,
                    input string what);
    logic [47:0] r;
    bit ok;
    u_serial_host_model.fetch(id, r, ok);
    check("answer framing", 48'h1, {47'h0, ok});
    check(what, exp, r);
  endtask
  task automatic wait_blank(input logic lvl);
    @(negedge clk);
    while (line_blank !== lvl) @(negedge clk);
  endtask
  // Skips one segment, then times switch and show intervals
  task automatic measure(input int show, input int sw);
    int hi, lo;
    logic [5:0] s1;
    hi = 0;
    lo = 0;
    wait_blank(1'b1);
    wait_blank(1'b0);
    wait_blank(1'b1);
    while (line_blank === 1'b1) begin
      hi++;
      @(negedge clk);
    end
    s1 = scan_line;
    while (line_blank !== 1'b1) begin
      lo++;
      @(negedge clk);
    end
    check("switch clocks", sw, hi);
    check("show clocks", show, lo);
    wait_blank(1'b0);
    check("next line", (s1 == 6'h01) ? 6'h00 : s1 + 6'h01, scan_line);
  endtask
  task automatic show_check(input logic [5:0] line, input logic [47:0] exp);
    // Skip segments whose line was fetched before the last command
    wait_blank(1'b1);
    wait_blank(1'b0);
    wait_blank(1'b1);
    while (!(scan_line === line && line_blank === 1'b0)) @(negedge clk);
    repeat (60) @(negedge clk);
    check("lit channels", exp, ch_on);
  endtask
  task automatic fill(input logic [47:0] m);
    for (int u = 0; u < 16; u++) wr(`ID_GS_STORE, unit_word(m, u));
  endtask

  initial begin
    rst = 1'b1;
    lfsr = 16'h0056;
    open_line_warn = 64'h0;
    short_line_warn = 64'h0;
    open_chan_warn = 48'h0;
    short_chan_warn = 48'h0;
    repeat (6) @(posedge clk);
    #5 rst = 1'b0;
    @(posedge clk);
    #5 check("idle channels", 48'h0, ch_on);
    check("idle flags", 48'h1, {45'h0, standby, power_save, sout});
    repeat (5) @(posedge sclk);
    rd(`ID_CFG0_RD, `CFG0_RESET, "config 0");
    rd(`ID_CFG1_RD, `CFG1_RESET, "config 1");
    rd(`ID_ODL_RD, `SEL_RESET, "open line select");
    rnd48(w);
    wr(`ID_CFG0_WR, w);
    v = (w & `CFG0_WMASK) | (`CFG0_RESET & ~`CFG0_WMASK);
    rd(`ID_CFG0_RD, v, "config 0 written");
    rnd48(w);
    wr(`ID_CFG1_WR, w);
    rd(`ID_CFG1_RD, (w & `CFG1_WMASK) | (`CFG1_RESET & ~`CFG1_WMASK), "cfg1");
    rnd48(w);
    wr(`ID_ODL_WR, w);
    rd(`ID_ODL_RD, w, "open line select");
    wr(`ID_SDL_WR, ~w);
    rd(`ID_SDL_RD, ~w, "short line select");
    wr(16'hAA55, 48'hFFFF_FFFF_FFFF);
    wr(16'hAA02, 48'h0000_0000_0000);
    rd(`ID_CFG0_RD, v, "config 0 kept");
    wr(`ID_DEFAULTS, 48'h0);
    rd(`ID_CFG0_RD, `CFG0_RESET, "config 0 default");
    rd(`ID_SDL_RD, `SEL_RESET, "short select default");
    rnd48(w);
    @(posedge clk);
    #5 open_line_warn = {w[15:0], w};
    short_line_warn = {w, ~w[15:0]};
    open_chan_warn = ~w;
    short_chan_warn = {w[23:0], w[47:24]};
    rd(`ID_OPEN_LO, open_line_warn[47:0], "open lines");
    rd(`ID_OPEN_HI, {32'h0, open_line_warn[63:48]}, "open high");
    rd(`ID_SHORT_LO, short_line_warn[47:0], "short lines");
    rd(`ID_SHORT_HI, {32'h0, short_line_warn[63:48]}, "short high");
    rd(`ID_OPEN_CH, open_chan_warn, "open channels");
    rd(`ID_SHORT_CH, short_chan_warn, "short channels");
    // Two scan lines keep frames short enough to cover every line
    wr(`ID_CFG0_WR, `CFG0_RESET | 48'h0000_0001_0000);
    rnd48(w);
    wr(`ID_CFG1_WR, cfg1v(10'h07F, 4'h1 | w[3:0]));
    measure(128, 4'h1 | w[3:0]);
    wr(`ID_CFG1_WR, cfg1v(`SEG_LONG_CODE, 4'hF));
    measure(1024, 15);
    wr(`ID_CFG1_WR, cfg1v({1'b0, w[12:4]}, 4'h1));
    measure(128, 1);
    rnd48(m1[0]);
    rnd48(m1[1]);
    fill(m1[0]);
    fill(m1[1]);
    wr(`ID_FRAME_SYNC, 48'h0);
    show_check(6'h00, m1[0]);
    show_check(6'h01, m1[1]);
    for (int l = 0; l < 3; l++) begin
      rnd48(m2[l]);
      fill(m2[l]);
    end
    show_check(6'h00, m1[0]);
    wr(`ID_FRAME_SYNC, 48'h0);
    show_check(6'h00, m2[2]);
    show_check(6'h01, m2[1]);
    wr(`ID_STBY_EN, 48'h0);
    check("standby set", 48'h1, {47'h0, standby});
    repeat (300) @(posedge clk);
    check("standby dark", 48'h0, ch_on);
    wr(`ID_STBY_CLR, 48'h0);
    check("standby clear", 48'h0, {47'h0, standby});
    wr(`ID_PWR_SAVE, 48'h0);
    wr(`ID_FRAME_SYNC, 48'h0);
    check("power save", 48'h1, {47'h0, power_save});
    repeat (300) @(posedge clk);
    check("power save dark", 48'h0, ch_on);
    wr(`ID_GS_STORE, 48'h0000_0001_0000);
    check("power save left", 48'h0, {47'h0, power_save});
    summarize();
  end
endmodule
